//--- design/strobe_pkg.sv
// Constants, types and register map for the row strobe and event interrupt.
package strobe_pkg;
  // Sample rate and system clock.
  localparam int SAMPLE_RATE_HZ = 8000;
  localparam int CLK_HZ = 20000000;
  localparam int CLK_PERIOD_NS = 50;
  // Row strobe timing in normal operation, in ms and in samples.
  localparam int ROW_PERIOD_MS = 200;
  localparam int ROW_HIGH_MS = 175;
  localparam int ROW_LOW_MS = 25;
  localparam int ROW_HIGH_SMP = ROW_HIGH_MS * SAMPLE_RATE_HZ / 1000;
  localparam int ROW_LOW_SMP = ROW_LOW_MS * SAMPLE_RATE_HZ / 1000;
  localparam int ROW_SMP = ROW_PERIOD_MS * SAMPLE_RATE_HZ / 1000;
  // Row strobe timing in message-cueing mode, in ns and in clock cycles.
  localparam int CUE_HIGH_NS = 109370;
  localparam int CUE_LOW_NS = 15630;
  localparam int CUE_HIGH_CYC = (CUE_HIGH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CUE_LOW_CYC = (CUE_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // Sample tick dividers: internal from clk_i, external after halving.
  localparam int EXT_CLK_KHZ = 1024;
  localparam int INT_DIV = CLK_HZ / SAMPLE_RATE_HZ;
  localparam int EXT_DIV = EXT_CLK_KHZ * 1000 / 2 / SAMPLE_RATE_HZ;
  // End-of-message marker positions per row.
  localparam int EOM_POSITIONS = 8;
  localparam int SEG_SMP = ROW_SMP / EOM_POSITIONS;
  // Memory rows and counter widths.
  localparam int NUM_ROWS = 2400;
  localparam int ROW_W = 12;
  localparam int CNT_W = 12;
  localparam int ADDR_W = 4;
  localparam int DATA_W = 16;
  // Register offsets.
  localparam logic [3:0] REG_CTRL = 4'h0;
  localparam logic [3:0] REG_STATUS = 4'h1;
  localparam logic [3:0] REG_MASK = 4'h2;
  localparam logic [3:0] REG_OPSTATE = 4'h3;
  localparam logic [3:0] REG_ROWADDR = 4'h4;
  localparam logic [3:0] REG_INTFLAGS = 4'h5;
  // Reset values.
  localparam logic [1:0] CTRL_RESET = 2'h0;
  localparam logic [2:0] MASK_RESET = 3'h0;
  // Control bits set by software.
  typedef struct packed {
    logic ext_clk_sel;
    logic cue_mode;
  } ctrl_t;
  // Events of one clock cycle; also the layout of status and mask.
  typedef struct packed {
    logic row_end;
    logic end_of_message_flag;
    logic ovf;
  } event_t;
  // Strobe sequencer states.
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_LEAD = 2'b01,
    ST_HIGH = 2'b10,
    ST_LOW = 2'b11
  } st_t;
endpackage : strobe_pkg

//--- design/sample_tick_gen.sv
// Sample tick generator from the system clock or the external sample clock.
`timescale 1ns/100ps
module sample_tick_gen
  import strobe_pkg::*;
#(
  parameter int INT_DIV_P = INT_DIV,
  parameter int EXT_DIV_P = EXT_DIV
)(
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic ext_sel_i,
  input wire logic external_sample_clock_i,
  output logic tick_o
);
  logic ext_prev_r;
  logic half_r;
  logic [CNT_W-1:0] int_cnt_r;
  logic [CNT_W-1:0] ext_cnt_r;
  wire ext_rise = external_sample_clock_i & ~ext_prev_r;
  // Halved clock rises on every second input rise, so duty cycle is moot.
  wire half_rise = ext_rise & ~half_r;
  wire int_wrap = int_cnt_r == CNT_W'(INT_DIV_P - 1);
  wire ext_wrap = half_rise && ext_cnt_r == CNT_W'(EXT_DIV_P - 1);
  wire tick_nxt = ext_sel_i ? ext_wrap : int_wrap;

  // Divide both sources down to one tick per sample.
  always_ff @(posedge clk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      ext_prev_r <= 1'b0;
      half_r <= 1'b0;
      int_cnt_r <= '0;
      ext_cnt_r <= '0;
      tick_o <= 1'b0;
    end
    else
    begin
      ext_prev_r <= external_sample_clock_i;
      half_r <= half_r ^ ext_rise;
      int_cnt_r <= int_wrap ? '0 : int_cnt_r + 1'b1;
      if (half_rise)
        ext_cnt_r <= ext_wrap ? '0 : ext_cnt_r + 1'b1;
      tick_o <= tick_nxt;
    end
  end
endmodule : sample_tick_gen

//--- design/row_strobe_and_event_interrupt.sv
// Row boundary strobe, end-of-operation events and interrupt outputs.
//
// The strobed register port and the placing of the registers were left to the implementer.
`timescale 1ns/100ps
// How it works
// - Strobe cycles once per row, 200 ms in normal operation
// - Normal row: high 175 ms, low 25 ms
// - Cueing row: high 109.37 us, low 15.63 us
// - Record start adds one extra low-length high
// - Strobe is open drain: pull low, release
// - Interrupt pin pulled low on overflow or END_OF_MESSAGE_FLAG
// - Each such ending operation interrupts anew
// - Next serial cycle start releases interrupt pin
// - Interrupt status readable by read instruction
// - Overflow set at memory end, record or play
// - END_OF_MESSAGE_FLAG flag set only during playback
// - Eight END_OF_MESSAGE_FLAG marker positions in every normal row; one, at row end, in a cueing row
// - External clock halved at once on entry
module row_strobe_and_event_interrupt
  import strobe_pkg::*;
#(
  parameter int NUM_ROWS_P = NUM_ROWS
)(
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic [ADDR_W-1:0] addr_i,
  input wire logic [DATA_W-1:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [DATA_W-1:0] rdata_o,
  input wire logic record_cmd_i,
  input wire logic play_cmd_i,
  input wire logic stop_cmd_i,
  input wire logic [ROW_W-1:0] start_row_i,
  input wire logic [EOM_POSITIONS-1:0] eom_marker_i,
  input wire logic serial_cycle_start_i,
  input wire logic read_interrupt_instruction_i,
  input wire logic external_sample_clock_i,
  output logic row_boundary_strobe_o,
  output logic row_boundary_strobe_oe_o,
  output logic int_o,
  output logic int_oe_o,
  output logic [ROW_W-1:0] row_addr_o,
  output logic [2:0] eom_pos_o,
  output logic busy_o,
  output logic overflow_flag_o,
  output logic end_of_message_flag_o,
  output logic irq_o
);
  ctrl_t ctrl_r;
  event_t status_r;
  event_t mask_r;
  st_t state_r;
  st_t state_nxt;
  logic rec_r;
  logic busy_r;
  logic [CNT_W-1:0] cnt_r;
  logic [CNT_W-1:0] cnt_nxt;
  logic [7:0] seg_cnt_r;
  logic [2:0] seg_r;
  logic [ROW_W-1:0] row_r;
  logic [ROW_W-1:0] row_nxt;
  logic int_low_r;
  logic ovf_flag_r;
  logic eom_flag_r;
  logic strobe_oe_r;
  logic zero_r;
  logic irq_r;
  logic [DATA_W-1:0] rdata_r;
  logic tick;

  // Phase length of a state in counted units, for either mode.
  function automatic logic [CNT_W-1:0] phase_len(input st_t st,
                                                 input logic cue);
    logic [CNT_W-1:0] len;
    len = '0;
    unique case (st)
      ST_LEAD: len = cue ? CNT_W'(CUE_LOW_CYC) : CNT_W'(ROW_LOW_SMP);
      ST_HIGH: len = cue ? CNT_W'(CUE_HIGH_CYC) : CNT_W'(ROW_HIGH_SMP);
      ST_LOW: len = cue ? CNT_W'(CUE_LOW_CYC) : CNT_W'(ROW_LOW_SMP);
      ST_IDLE: len = '0;
    endcase
    return len;
  endfunction : phase_len

  sample_tick_gen u_tick (
    .clk_i(clk_i),
    .reset_i(reset_i),
    .ext_sel_i(ctrl_r.ext_clk_sel),
    .external_sample_clock_i(external_sample_clock_i),
    .tick_o(tick)
  );

  // Cueing counts system clocks; normal operation counts samples.
  wire adv = (state_r != ST_IDLE) & (ctrl_r.cue_mode | tick);
  wire phase_done = adv && cnt_r == phase_len(state_r, ctrl_r.cue_mode) - 1'b1;
  wire start_op = record_cmd_i | play_cmd_i;
  wire row_done = state_r == ST_LOW && phase_done;
  wire last_row = row_r == ROW_W'(NUM_ROWS_P - 1);
  // Eight marker positions, one per eighth of a normal row; cueing checks all markers at row end.
  wire in_row = state_r == ST_HIGH || state_r == ST_LOW;
  wire seg_done = in_row && !ctrl_r.cue_mode && tick &&
                  seg_cnt_r == 8'(SEG_SMP - 1);
  wire eom_seg = seg_done && eom_marker_i[seg_r];
  wire eom_cue = ctrl_r.cue_mode && row_done && |eom_marker_i;
  // End-of-message only during playback.
  wire ev_eom = !rec_r && (eom_seg || eom_cue) && !stop_cmd_i;
  // Overflow at the end of the array in record or playback.
  wire ev_ovf = row_done && last_row && !stop_cmd_i;
  wire ev_row = row_done && !stop_cmd_i;
  wire op_end = ev_ovf | ev_eom;
  event_t ev;
  assign ev = '{row_end: ev_row, end_of_message_flag: ev_eom, ovf: ev_ovf};

  // Register decode.
  wire wr_ctrl = wr_i && addr_i == REG_CTRL;
  wire wr_status = wr_i && addr_i == REG_STATUS;
  wire wr_mask = wr_i && addr_i == REG_MASK;
  wire [2:0] status_clr = wr_status ? wdata_i[2:0] : 3'h0;
  // Events win over a write-one clear in the same cycle.
  wire [2:0] status_nxt = (status_r & ~status_clr) | ev;
  wire [2:0] mask_nxt = wr_mask ? wdata_i[2:0] : mask_r;
  wire [DATA_W-1:0] rd_mux =
    addr_i == REG_CTRL ? DATA_W'(ctrl_r) :
    addr_i == REG_STATUS ? DATA_W'(status_r) :
    addr_i == REG_MASK ? DATA_W'(mask_r) :
    addr_i == REG_OPSTATE ? DATA_W'({strobe_oe_r, rec_r, state_r}) :
    addr_i == REG_ROWADDR ? DATA_W'(row_r) :
    addr_i == REG_INTFLAGS ? DATA_W'({int_low_r, eom_flag_r, ovf_flag_r}) :
    16'h0000;

  // Sequencer next state: lead phase only on record start.
  always_comb
  begin
    state_nxt = state_r;
    cnt_nxt = adv ? cnt_r + 1'b1 : cnt_r;
    row_nxt = row_r;
    if (stop_cmd_i)
      state_nxt = ST_IDLE;
    else if (start_op)
    begin
      state_nxt = record_cmd_i ? ST_LEAD : ST_HIGH;
      cnt_nxt = '0;
      row_nxt = start_row_i;
    end
    else if (op_end)
      state_nxt = ST_IDLE;
    else if (phase_done)
    begin
      cnt_nxt = '0;
      unique case (state_r)
        ST_LEAD: state_nxt = ST_HIGH;
        ST_HIGH: state_nxt = ST_LOW;
        ST_LOW:
        begin
          state_nxt = ST_HIGH;
          row_nxt = row_r + 1'b1;
        end
        ST_IDLE: state_nxt = ST_IDLE;
      endcase
    end
  end

  // Sequencer registers.
  always_ff @(posedge clk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      state_r <= ST_IDLE;
      cnt_r <= '0;
      row_r <= '0;
      rec_r <= 1'b0;
      busy_r <= 1'b0;
    end
    else
    begin
      state_r <= state_nxt;
      busy_r <= state_nxt != ST_IDLE; // Busy output straight from a flop.
      cnt_r <= cnt_nxt;
      row_r <= row_nxt;
      if (start_op)
        rec_r <= record_cmd_i;
    end
  end

  // Marker position tracking within the row.
  always_ff @(posedge clk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      seg_cnt_r <= '0;
      seg_r <= '0;
    end
    else if (start_op || row_done)
    begin
      seg_cnt_r <= '0;
      seg_r <= '0;
    end
    else if (seg_done)
    begin
      seg_cnt_r <= '0;
      seg_r <= seg_r + 1'b1;
    end
    else if (in_row && !ctrl_r.cue_mode && tick)
      seg_cnt_r <= seg_cnt_r + 1'b1;
  end

  // Pin drivers: open drain, low only while the row end phase runs.
  always_ff @(posedge clk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      strobe_oe_r <= 1'b0;
      zero_r <= 1'b0;
    end
    else
    begin
      strobe_oe_r <= state_nxt == ST_LOW;
      zero_r <= 1'b0;
    end
  end

  // Interrupt pin and operation flags; a new event wins over the clear.
  always_ff @(posedge clk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      int_low_r <= 1'b0;
      ovf_flag_r <= 1'b0;
      eom_flag_r <= 1'b0;
    end
    else
    begin
      if (op_end)
        int_low_r <= 1'b1;
      else if (serial_cycle_start_i)
        int_low_r <= 1'b0;
      if (ev_ovf)
        ovf_flag_r <= 1'b1;
      else if (start_op)
        ovf_flag_r <= 1'b0;
      if (ev_eom)
        eom_flag_r <= 1'b1;
      else if (start_op)
        eom_flag_r <= 1'b0;
    end
  end

  // Register file and read port; the instruction also reads the flags.
  always_ff @(posedge clk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      ctrl_r <= CTRL_RESET;
      status_r <= '0;
      mask_r <= MASK_RESET;
      irq_r <= 1'b0;
      rdata_r <= '0;
    end
    else
    begin
      if (wr_ctrl)
        ctrl_r <= wdata_i[1:0];
      status_r <= status_nxt;
      mask_r <= mask_nxt;
      irq_r <= |(status_nxt & mask_nxt);
      if (read_interrupt_instruction_i)
        rdata_r <= DATA_W'({int_low_r, eom_flag_r, ovf_flag_r});
      else if (rd_i)
        rdata_r <= rd_mux;
      else
        rdata_r <= '0;
    end
  end

  assign row_boundary_strobe_o = zero_r;
  assign row_boundary_strobe_oe_o = strobe_oe_r;
  assign int_o = zero_r;
  assign int_oe_o = int_low_r;
  assign row_addr_o = row_r;
  assign eom_pos_o = seg_r;
  assign busy_o = busy_r;
  assign overflow_flag_o = ovf_flag_r;
  assign end_of_message_flag_o = eom_flag_r;
  assign irq_o = irq_r;
  assign rdata_o = rdata_r;

  // Helper: samples counted across the high and low phases of one row.
  logic [CNT_W-1:0] row_smp_h;
  always_ff @(posedge clk_i or posedge reset_i)
  begin
    if (reset_i)
      row_smp_h <= '0;
    else if (start_op || row_done || state_r == ST_IDLE)
      row_smp_h <= '0;
    else if (in_row && adv)
      row_smp_h <= row_smp_h + 1'b1;
  end

  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (reset_i);

  row_period_a: assert property (ev_row && !ctrl_r.cue_mode
    |-> row_smp_h == CNT_W'(ROW_SMP - 1))
    else $error("row period is not one full row of samples");
  high_len_a: assert property (state_r == ST_HIGH && !ctrl_r.cue_mode
    |-> cnt_r < CNT_W'(ROW_HIGH_SMP))
    else $error("normal high phase too long");
  low_len_a: assert property ($rose(strobe_oe_r) ##1 strobe_oe_r
    && !stop_cmd_i && !start_op && !ctrl_r.cue_mode
    |-> $past(state_r) == ST_LOW)
    else $error("strobe pulled low outside the low phase");
  cue_low_a: assert property (state_r == ST_LOW && ctrl_r.cue_mode
    && !start_op && !stop_cmd_i && cnt_r == CNT_W'(CUE_LOW_CYC - 1)
    |=> state_r != ST_LOW)
    else $error("cueing low phase not ended on time");
  record_lead_a: assert property (record_cmd_i && !stop_cmd_i
    |=> state_r == ST_LEAD && !strobe_oe_r)
    else $error("record start without extra high period");
  open_drain_a: assert property (!row_boundary_strobe_o && !int_o)
    else $error("open drain pin driven high");
  int_set_a: assert property (op_end |=> int_oe_o [*2] or
    (int_oe_o ##1 $past(serial_cycle_start_i)))
    else $error("operation end without interrupt");
  int_clear_a: assert property (serial_cycle_start_i && !op_end
    |=> !int_oe_o)
    else $error("interrupt not released by serial cycle");
  int_hold_a: assert property (int_oe_o && !serial_cycle_start_i
    |=> int_oe_o)
    else $error("interrupt released without a serial cycle");
  eom_play_a: assert property (ev_eom |-> !rec_r ##1 eom_flag_r)
    else $error("end of message flagged outside playback");
  ovf_end_a: assert property (ev_ovf && !start_op
    |-> row_r == ROW_W'(NUM_ROWS_P - 1) ##1 ovf_flag_r && !busy_o)
    else $error("overflow not at array end");
  read_int_a: assert property (read_interrupt_instruction_i
    |=> rdata_o[2:0] == $past({int_low_r, eom_flag_r, ovf_flag_r}))
    else $error("read interrupt returns wrong status");

  record_start_c: cover property (record_cmd_i ##1 state_r == ST_LEAD);
  eom_play_c: cover property (ev_eom ##1 int_oe_o);
  overflow_c: cover property (ev_ovf && rec_r);
  cue_row_c: cover property (ev_row && ctrl_r.cue_mode);
endmodule : row_strobe_and_event_interrupt

//--- testbench/host_model.sv
// Host side model: pull-ups, sample clock source and strobe watcher.
`timescale 1ns/100ps
module host_model
  import strobe_pkg::*;
(
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic strobe_oe_i,
  input wire logic int_oe_i,
  output logic ext_clk_o,
  output logic strobe_pin_o,
  output logic int_pin_o,
  output int row_cnt_o,
  output int int_cnt_o,
  output int high_len_o
);
  logic [1:0] sync_r;
  logic int_d_r;
  int run_r;
  // Pull-ups give the high level whenever the device lets a pin go.
  assign strobe_pin_o = strobe_oe_i ? 1'b0 : 1'b1;
  assign int_pin_o = int_oe_i ? 1'b0 : 1'b1;
  // The host supplies the 1024 kHz sample clock without a break.
  initial
  begin
    ext_clk_o = 1'b0;
    forever #488.28 ext_clk_o = ~ext_clk_o;
  end
  // Strobe edges pass two flops before rows are counted and timed.
  always_ff @(posedge clk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      sync_r <= 2'b11;
      int_d_r <= 1'b1;
      run_r <= 0;
      row_cnt_o <= 0;
      int_cnt_o <= 0;
      high_len_o <= 0;
    end
    else
    begin
      sync_r <= {sync_r[0], strobe_pin_o};
      int_d_r <= int_pin_o;
      run_r <= (sync_r[1] != sync_r[0]) ? 1 : run_r + 1;
      if (sync_r[1] && !sync_r[0])
      begin
        row_cnt_o <= row_cnt_o + 1;
        high_len_o <= run_r;
      end
      if (int_d_r && !int_pin_o)
        int_cnt_o <= int_cnt_o + 1;
    end
  end
endmodule : host_model

//--- testbench/testbench.sv
// Self-checking bench for the row strobe and event interrupt block.
`timescale 1ns/100ps
module testbench
  import strobe_pkg::*;
;
  logic clk_i, reset_i, wr_i, rd_i, read_interrupt_instruction, rec, play, stop, ser;
  logic [ADDR_W-1:0] addr_i;
  logic [DATA_W-1:0] wdata_i, rdata_o, d;
  logic [ROW_W-1:0] start_row_i, row_addr_o;
  logic [EOM_POSITIONS-1:0] mark;
  logic [2:0] eom_pos_o;
  logic ext_clk, strobe_o, strobe_oe, int_o, int_oe, busy_o, ovf, end_of_message_flag, irq;
  logic strobe_pin, int_pin;
  int row_cnt, int_cnt, high_len, t_rec, t_play, lo, rows0, ints0;
  int error_cnt = 0;
  int samples_checked = 0;
  int cyc = 0;
  row_strobe_and_event_interrupt #(.NUM_ROWS_P(3))
    row_strobe_and_event_interrupt_inst (.clk_i(clk_i), .reset_i(reset_i),
    .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i),
    .rdata_o(rdata_o), .record_cmd_i(rec), .play_cmd_i(play),
    .stop_cmd_i(stop), .start_row_i(start_row_i), .eom_marker_i(mark),
    .serial_cycle_start_i(ser), .read_interrupt_instruction_i(read_interrupt_instruction),
    .external_sample_clock_i(ext_clk), .row_boundary_strobe_o(strobe_o),
    .row_boundary_strobe_oe_o(strobe_oe), .int_o(int_o), .int_oe_o(int_oe),
    .row_addr_o(row_addr_o), .eom_pos_o(eom_pos_o), .busy_o(busy_o),
    .overflow_flag_o(ovf), .end_of_message_flag_o(end_of_message_flag), .irq_o(irq));
  host_model host_model_inst (.clk_i(clk_i), .reset_i(reset_i),
    .strobe_oe_i(strobe_oe), .int_oe_i(int_oe), .ext_clk_o(ext_clk),
    .strobe_pin_o(strobe_pin), .int_pin_o(int_pin), .row_cnt_o(row_cnt),
    .int_cnt_o(int_cnt), .high_len_o(high_len));
  // Prints the counts and the verdict, then stops the run.
  task automatic complete_run;
    $display("checks %0d mismatches %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : complete_run
  // Compares a seen value with the expected one and counts both.
  task automatic check(input string what, input logic [31:0] seen,
    input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("mismatch %s expected %0h seen %0h", what, exp, seen);
    end
  endtask : check
  // One-cycle register write.
  task automatic wr(input logic [3:0] a, input logic [15:0] v);
    @(posedge clk_i);
    wr_i <= 1'b1;
    addr_i <= a;
    wdata_i <= v;
    @(posedge clk_i);
    wr_i <= 1'b0;
  endtask : wr
  // Register read, or the interrupt status instruction when ri is set.
  task automatic rd(input logic [3:0] a, input logic ri);
    @(posedge clk_i);
    rd_i <= !ri;
    read_interrupt_instruction <= ri;
    addr_i <= a;
    @(posedge clk_i);
    rd_i <= 1'b0;
    read_interrupt_instruction <= 1'b0;
    @(negedge clk_i);
    d = rdata_o;
  endtask : rd
  // One-cycle pulse on {serial start, stop, play, record}.
  task automatic go(input logic [3:0] k, input logic [11:0] row);
    @(posedge clk_i);
    {ser, stop, play, rec} <= k;
    start_row_i <= row;
    @(posedge clk_i);
    {ser, stop, play, rec} <= 4'h0;
    @(negedge clk_i);
  endtask : go
  // Cycles to the first pull-low of the strobe, then its length.
  task automatic meas(output int hi, output int lw);
    hi = 0;
    lw = 0;
    while (strobe_oe !== 1'b1 && hi < 9000)
    begin
      @(negedge clk_i);
      hi++;
    end
    while (strobe_oe === 1'b1 && lw < 9000)
    begin
      @(negedge clk_i);
      lw++;
    end
  endtask : meas
  // Waits, bounded, for the operation to end and the pins to settle.
  task automatic wait_idle;
    int n;
    n = 0;
    while (busy_o !== 1'b0 && n < 20000)
    begin
      @(negedge clk_i);
      n++;
    end
    repeat (4) @(negedge clk_i);
  endtask : wait_idle
  // Free-running clock at 20 MHz.
  initial
  begin
    clk_i = 1'b0;
    forever #25 clk_i = ~clk_i;
  end
  // A hang is cut short well after the expected run length.
  always @(posedge clk_i)
  begin
    cyc <= cyc + 1;
    if (cyc == 80000)
    begin
      error_cnt++;
      complete_run();
    end
  end
  // Main sequence of scenarios.
  initial
  begin
    {wr_i, rd_i, read_interrupt_instruction, rec, play, stop, ser} = 7'h00;
    addr_i = 4'h0;
    wdata_i = 16'h0000;
    start_row_i = 12'h000;
    mark = 8'hFF;
    reset_i = 1'b1;
    repeat (20) @(posedge clk_i);
    reset_i <= 1'b0;
    rd(REG_CTRL, 1'b0);
    check("ctrl", d, 16'h0000);
    rd(REG_MASK, 1'b0);
    check("mask", d, 16'h0000);
    rd(4'hF, 1'b0);
    check("unmapped", d, 16'h0000);
    check("pins", {strobe_o, int_o, int_oe, strobe_pin}, 4'h1);
    go(4'h1, 12'h000);
    rd(REG_OPSTATE, 1'b0);
    check("lead state", d, 16'h0005);
    go(4'h4, 12'h000);
    wait_idle();
    check("stop", {busy_o, int_oe}, 2'h0);
    wr(REG_CTRL, 16'h0001);
    wr(REG_MASK, 16'h0003);
    rows0 = row_cnt;
    go(4'h1, 12'h000);
    meas(t_rec, lo);
    wait_idle();
    check("cue low", lo, CUE_LOW_CYC);
    check("cue high", high_len, CUE_HIGH_CYC);
    check("rows", row_cnt - rows0, 3);
    check("rec ovf", ovf, 1'b1);
    check("rec eom", end_of_message_flag, 1'b0);
    check("int pin", {int_pin, strobe_pin, irq}, 3'h3);
    rd(REG_INTFLAGS, 1'b0);
    check("intflags", d, 16'h0005);
    rd(REG_CTRL, 1'b1);
    check("read_interrupt_instruction", d[2:0], 3'h5);
    go(4'h8, 12'h000);
    check("release", int_oe, 1'b0);
    wr(REG_STATUS, 16'h0001);
    rd(REG_STATUS, 1'b0);
    check("w1c", {d[0], irq}, 2'h0);
    mark <= 8'h00;
    go(4'h2, 12'h001);
    meas(t_play, lo);
    check("lead len", t_rec - t_play, CUE_LOW_CYC);
    wait_idle();
    check("play ovf", {ovf, end_of_message_flag}, 2'h2);
    go(4'h8, 12'h000);
    for (int n = 0; n < 8; n++)
    begin
      mark <= 8'h01 << n;
      ints0 = int_cnt;
      go(4'h2, 12'h001);
      wait_idle();
      check("eom pos", {end_of_message_flag, ovf, row_addr_o}, 14'h2001);
      check("new int", int_cnt - ints0, 1);
      check("cue seg", eom_pos_o, 3'h0);
      go(4'h8, 12'h000);
    end
    mark <= 8'h01;
    ints0 = int_cnt;
    go(4'h2, 12'h002);
    wait_idle();
    check("both", {ovf, end_of_message_flag}, 2'h3);
    check("one int", int_cnt - ints0, 1);
    rd(REG_INTFLAGS, 1'b0);
    check("flags both", d, 16'h0007);
    wr(REG_MASK, 16'h0000);
    repeat (2) @(negedge clk_i);
    check("masked", irq, 1'b0);
    wr(REG_MASK, 16'h0003);
    repeat (2) @(negedge clk_i);
    check("unmasked", irq, 1'b1);
    wr(REG_STATUS, 16'h0003);
    repeat (2) @(negedge clk_i);
    check("cleared", irq, 1'b0);
    go(4'h8, 12'h000);
    check("final release", int_pin, 1'b1);
    complete_run();
  end
endmodule : testbench
